/* File: design/ihm_bit.sv */
// bit engine: start, stop and single clocked bits on the open-drain pair
// assumes pins are synchronous to clk and scl counts are at least the minimum
`timescale 1ns/100ps
module ihm_bit
(
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  input  wire logic [7:0]           hi_cnt,
  input  wire logic [7:0]           lo_cnt,
  input  wire ihm_pkg::ihm_bcmd_t   cmd,
  output logic                      rdy,
  output logic                      done,
  output logic                      rx,
  input  wire ihm_pkg::ihm_pin_in_t pin_i,
  output ihm_pkg::ihm_pin_out_t     pin_o
);
  import ihm_pkg::*;

  typedef enum logic [3:0] {
    B_IDLE = 4'h1,
    B_LOW  = 4'h2,
    B_HIGH = 4'h4,
    B_HOLD = 4'h8
  } ihm_bst_t;

  typedef struct packed {
    ihm_bst_t        st;
    ihm_bop_t        op;
    logic [ACC_W-1:0] acc;   // 125 ns count from a 10 ns clock, no drift
    logic [7:0]      cnt;
    logic            scl_oe;
    logic            sda_oe;
    logic            done;
    logic            rx;
  } ihm_bstate_t;

  ihm_bstate_t q;           // registered state
  ihm_bstate_t n;           // next state
  logic        tick;        // one scl count elapsed

  // next state: low, high and hold phases advance on count ticks only; idle leaves on a command
  always_comb
  begin
    n = q;
    n.done = 1'b0;
    tick = (q.acc + ACC_STEP) >= ACC_WRAP;
    n.acc = tick ? q.acc + ACC_STEP - ACC_WRAP : q.acc + ACC_STEP;
    unique case (q.st)
      B_IDLE:
      begin
        if (cmd.valid)
        begin
          // sda is set up here, while scl is low or idle high; start and stop move it again in B_HIGH
          n.op = cmd.op;
          n.sda_oe = (cmd.op == BOP_STOP) | ((cmd.op == BOP_BIT) & ~cmd.bitv);
          n.cnt = lo_cnt;
          n.st = B_LOW;
        end
      end
      B_LOW:
      begin
        if (tick)
        begin
          if (q.cnt == 8'h00)
          begin
            n.scl_oe = 1'b0;
            n.cnt = hi_cnt;
            n.st = B_HIGH;
          end
          else
            n.cnt = q.cnt - 8'h01;
        end
      end
      B_HIGH:
      begin
        // a slave holding scl low stretches the high time
        if (tick & pin_i.scl)
        begin
          if (q.cnt == 8'h00)
          begin
            n.cnt = hi_cnt;
            unique case (q.op)
              BOP_START:
              begin
                n.sda_oe = 1'b1;
                n.st = B_HOLD;
              end
              BOP_STOP:
              begin
                n.sda_oe = 1'b0;
                n.st = B_HOLD;
              end
              BOP_BIT:
              begin
                n.rx = pin_i.sda;
                n.scl_oe = 1'b1;
                n.done = 1'b1;
                n.st = B_IDLE;
              end
            endcase
          end
          else
            n.cnt = q.cnt - 8'h01;
        end
      end
      B_HOLD:
      begin
        // after a stop this is the idle time before the bus counts as free
        if (tick)
        begin
          if (q.cnt == 8'h00)
          begin
            n.scl_oe = (q.op == BOP_START);
            n.done = 1'b1;
            n.st = B_IDLE;
          end
          else
            n.cnt = q.cnt - 8'h01;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      q <= '{st: B_IDLE, op: BOP_STOP, default: '0};
    else
      q <= n;
  end

  assign rdy = (q.st == B_IDLE);
  assign done = q.done;
  assign rx = q.rx;
  assign pin_o = '{scl_o: 1'b0, scl_oe: q.scl_oe, sda_o: 1'b0, sda_oe: q.sda_oe};
endmodule

/* File: design/ihm_pkg.sv */
// package for the two-wire host master: bus carriers, register map, codes, timing
// assumes a single 100 MHz clock and an Avalon-MM register master
package ihm_pkg;
  localparam int AW = 6;                       // byte address width of the register window
  localparam int CLK_PERIOD_PS = 10000;        // 100 MHz clock period
  localparam int FREQ_BASE_KHZ = 8000;         // bus kHz = base / (high + low counts)
  localparam int UNIT_PS = 1000000000 / FREQ_BASE_KHZ; // one scl count, 125 ns
  localparam int ACC_W = 17;                   // fractional tick accumulator width
  localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(CLK_PERIOD_PS);
  localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(UNIT_PS);
  localparam int US_PS = 1000000;              // one microsecond in ps
  localparam logic [6:0] US_CYC = 7'(US_PS / CLK_PERIOD_PS); // cycles per microsecond
  localparam int PROG_RST_MS = 5;              // default eeprom programming wait
  localparam logic [15:0] PROG_RST = 16'(PROG_RST_MS * 1000); // same, in microseconds
  localparam logic [7:0] SCL_MIN = 8'h03;      // least high or low count
  localparam logic [7:0] SCL_MAX = 8'hFF;      // count register ceiling
  localparam logic [7:0] SCLH_RST = 8'h14;     // 200 kHz, even duty after reset
  localparam logic [7:0] SCLL_RST = 8'h14;
  localparam logic [7:0] PAGE_RST = 8'h08;     // safe page size when target is unknown
  localparam logic [15:0] FREQ_RST = 16'h00C8; // 200 kHz shown after reset
  // register byte offsets
  localparam logic [AW-1:0] REG_CTRL = 6'h00;
  localparam logic [AW-1:0] REG_STAT = 6'h04;
  localparam logic [AW-1:0] REG_SLV  = 6'h08;
  localparam logic [AW-1:0] REG_OFF  = 6'h0C;
  localparam logic [AW-1:0] REG_LEN  = 6'h10;
  localparam logic [AW-1:0] REG_PAGE = 6'h14;
  localparam logic [AW-1:0] REG_SCLH = 6'h18;
  localparam logic [AW-1:0] REG_SCLL = 6'h1C;
  localparam logic [AW-1:0] REG_FREQ = 6'h20;
  localparam logic [AW-1:0] REG_WDAT = 6'h24;
  localparam logic [AW-1:0] REG_RDAT = 6'h28;
  localparam logic [AW-1:0] REG_PROG = 6'h2C;
  // field positions
  localparam int CTRL_GO = 0;                  // write 1 to start a transfer
  localparam int CTRL_RD = 1;                  // 1 = single byte read, 0 = write
  localparam int CTRL_IGN = 2;                 // keep sending after a missing acknowledge
  localparam int CTRL_PGEN = 3;                // split writes into eeprom pages
  localparam int STAT_BUSY = 0;
  localparam int STAT_RES = 4;                 // three-bit result code
  // avalon request and answer
  typedef struct packed {
    logic            read;
    logic            write;
    logic [AW-1:0]   address;
    logic [31:0]     writedata;
  } ihm_avs_req_t;
  typedef struct packed {
    logic            waitrequest;
    logic [31:0]     readdata;
  } ihm_avs_rsp_t;
  // open-drain pins
  typedef struct packed {
    logic scl;
    logic sda;
  } ihm_pin_in_t;
  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } ihm_pin_out_t;
  // bit engine commands
  typedef enum logic [2:0] {
    BOP_START = 3'h1,
    BOP_STOP  = 3'h2,
    BOP_BIT   = 3'h4
  } ihm_bop_t;
  typedef struct packed {
    logic      valid;
    ihm_bop_t  op;
    logic      bitv;
  } ihm_bcmd_t;
  // transfer results
  typedef enum logic [2:0] {
    RES_OK        = 3'h0,
    RES_ADDR_NACK = 3'h1,
    RES_DATA_NACK = 3'h2,
    RES_RDACK_BAD = 3'h3,
    RES_SDA_LOW   = 3'h4,
    RES_SCL_LOW   = 3'h5
  } ihm_res_t;
endpackage

/* File: design/ihm_top.sv */
// two-wire host master with an avalon-mm register window
// assumes pins synchronous to REF_CLK; the wire level is resolved outside from the enables
//
// The Avalon-MM interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
// Contract
// - master alone makes start, clocks, stop
// - ninth clock carries receiver acknowledge
// - sda steady while scl high, sampled then
// - start: sda falls while scl high
// - stop: sda rises while scl high
// - bus busy from start until idle after stop
// - first byte: seven address bits, direction last
// - direction 0 write, 1 read
// - address nack: stop, report address result
// - data nack: stop, report data result
// - last read byte nacked; low sda reported
// - check both lines high before start
// - separate high and low counts set frequency
// - each count at least three
// - requested frequency rounds to nearest setting
// - ignore-acknowledge option keeps sending
// - stop after each page, wait programming time
// - page length configurable up to 128
// - read: address, offset, repeated start, read
// - write: address, offset, data in one transfer
module ihm_top
#(
  parameter int DEPTH = 128              // write buffer bytes, also the largest page
)
(
  input  wire logic                  REF_CLK,
  input  wire logic                  ARST_N,
  input  wire ihm_pkg::ihm_avs_req_t AVS_REQ,
  output ihm_pkg::ihm_avs_rsp_t      AVS_RSP,
  input  wire ihm_pkg::ihm_pin_in_t  PIN_I,
  output ihm_pkg::ihm_pin_out_t      PIN_O
);
  import ihm_pkg::*;

  localparam int IW = $clog2(DEPTH);     // buffer index width

  typedef enum logic [6:0] {
    M_IDLE = 7'h01,
    M_CHK  = 7'h02,
    M_STA  = 7'h04,
    M_TXB  = 7'h08,
    M_RXB  = 7'h10,
    M_STO  = 7'h20,
    M_PROG = 7'h40
  } ihm_mst_t;

  typedef enum logic [3:0] {
    K_AW  = 4'h1,                        // address, write direction
    K_SUB = 4'h2,                        // register offset
    K_DAT = 4'h4,                        // data byte
    K_AR  = 4'h8                         // address, read direction
  } ihm_kind_t;

  typedef struct packed {
    logic                   ack;         // bus access answered this cycle
    logic [31:0]            rdata;       // read data held for the answer cycle
    ihm_mst_t               st;
    ihm_kind_t              kind;
    logic                   wt;          // bit command outstanding
    logic [3:0]             bitn;        // bit within byte, 8 = acknowledge slot
    logic [7:0]             sh;          // byte shift register
    logic                   rd;
    logic                   ign;
    logic                   pgen;
    logic [7:0]             slv;
    logic [7:0]             off;
    logic [7:0]             len;
    logic [7:0]             page;
    logic [7:0]             sclh;
    logic [7:0]             scll;
    logic [15:0]            freq;
    logic [15:0]            prog;
    logic [IW-1:0]          wptr;
    logic [IW-1:0]          idx;
    logic [7:0]             left;
    logic [7:0]             pg;
    logic                   fin;         // stop ends the transfer
    ihm_res_t               res;
    logic [7:0]             rxd;
    logic [15:0]            tus;
    logic [6:0]             pre;
    logic [DEPTH-1:0][7:0]  mem;
  } ihm_mstate_t;

  ihm_mstate_t q;                        // registered state
  ihm_mstate_t n;                        // next state
  ihm_bcmd_t   bc;                       // command to the bit engine
  logic        brdy;                     // bit engine idle
  logic        bdone;                    // bit engine finished a command
  logic        brx;                      // sampled sda of the last bit
  logic        req;                      // avalon access pending
  logic        wr_go;                    // accepted write this cycle
  logic [31:0] rv;                       // read mux
  logic [15:0] fsum;                     // rounded high plus low counts
  logic        nack;                     // acknowledge slot saw sda high

  // clamp a count into the legal range
  function automatic logic [7:0] ihm_clamp(input logic [15:0] v);
    if (v < 16'(SCL_MIN))
      return SCL_MIN;
    else if (v > 16'(SCL_MAX))
      return SCL_MAX;
    else
      return v[7:0];
  endfunction

  // outgoing address byte: seven address bits then the direction
  function automatic logic [7:0] ihm_abyte(input logic [7:0] a, input logic r);
    return {a[7:1], r};
  endfunction

  assign req = AVS_REQ.read | AVS_REQ.write;
  assign wr_go = AVS_REQ.write & q.ack;

  // register read mux; unmapped offsets read zero
  always_comb
  begin
    rv = '0;
    case (AVS_REQ.address)
      REG_CTRL:
      begin
        rv[CTRL_RD] = q.rd;
        rv[CTRL_IGN] = q.ign;
        rv[CTRL_PGEN] = q.pgen;
      end
      REG_STAT:
      begin
        rv[STAT_BUSY] = (q.st != M_IDLE);
        rv[STAT_RES +: 3] = q.res;
      end
      REG_SLV:  rv[7:0] = q.slv;
      REG_OFF:  rv[7:0] = q.off;
      REG_LEN:  rv[7:0] = q.len;
      REG_PAGE: rv[7:0] = q.page;
      REG_SCLH: rv[7:0] = q.sclh;
      REG_SCLL: rv[7:0] = q.scll;
      REG_FREQ: rv[15:0] = q.freq;
      REG_RDAT: rv[7:0] = q.rxd;
      REG_PROG: rv[15:0] = q.prog;
      default:  rv = '0;
    endcase
  end

  // nearest count sum for a requested frequency in kHz
  always_comb
  begin
    fsum = 16'hFFFF;
    if (AVS_REQ.writedata[15:0] != 16'h0000)
      fsum = 16'((FREQ_BASE_KHZ + 32'(AVS_REQ.writedata[15:1])) /
                 32'(AVS_REQ.writedata[15:0]));
  end

  // next state: bus slave, configuration and transfer sequencer
  always_comb
  begin
    n = q;
    bc = '{valid: 1'b0, op: BOP_BIT, bitv: 1'b1};
    nack = brx;
    // one wait cycle per access; read data is registered
    n.ack = req & ~q.ack;
    if (req & ~q.ack)
      n.rdata = rv;
    if (wr_go)
    begin
      case (AVS_REQ.address)
        REG_CTRL:
        begin
          n.rd = AVS_REQ.writedata[CTRL_RD];
          n.ign = AVS_REQ.writedata[CTRL_IGN];
          n.pgen = AVS_REQ.writedata[CTRL_PGEN];
        end
        REG_SLV:  n.slv = AVS_REQ.writedata[7:0];
        REG_OFF:  n.off = AVS_REQ.writedata[7:0];
        REG_LEN:  n.len = AVS_REQ.writedata[7:0];
        REG_PAGE:
        begin
          // zero or oversize pages fall back to the buffer size
          if ((AVS_REQ.writedata[7:0] == 8'h00) || (32'(AVS_REQ.writedata[7:0]) > DEPTH))
            n.page = 8'(DEPTH);
          else
            n.page = AVS_REQ.writedata[7:0];
        end
        REG_SCLH: n.sclh = ihm_clamp({8'h00, AVS_REQ.writedata[7:0]});
        REG_SCLL: n.scll = ihm_clamp({8'h00, AVS_REQ.writedata[7:0]});
        REG_FREQ:
        begin
          if (AVS_REQ.writedata[15:0] != 16'h0000)
          begin
            n.freq = AVS_REQ.writedata[15:0];
            n.sclh = ihm_clamp({1'b0, fsum[15:1]});
            n.scll = ihm_clamp(fsum - {1'b0, fsum[15:1]});
          end
        end
        REG_WDAT:
        begin
          n.mem[q.wptr] = AVS_REQ.writedata[7:0];
          n.wptr = q.wptr + IW'(1);
        end
        REG_PROG: n.prog = AVS_REQ.writedata[15:0];
        default:  n.len = q.len;
      endcase
    end
    // bit commands: one at a time, wait for done
    bc.valid = ~q.wt & ((q.st == M_STA) | (q.st == M_TXB) | (q.st == M_RXB) | (q.st == M_STO));
    unique case (q.st)
      M_STA:   bc.op = BOP_START;
      M_STO:   bc.op = BOP_STOP;
      M_TXB:   bc.bitv = (q.bitn == 4'h8) ? 1'b1 : q.sh[7];
      default: bc.bitv = 1'b1;  // read bits and the final nack release sda
    endcase
    if (bc.valid & brdy)
      n.wt = 1'b1;
    if (bdone)
      n.wt = 1'b0;
    unique case (q.st)
      M_IDLE:
      begin
        // a start request while busy is ignored
        if (wr_go && (AVS_REQ.address == REG_CTRL) && AVS_REQ.writedata[CTRL_GO])
        begin
          n.st = M_CHK;
          n.wptr = '0;
          n.idx = '0;
          n.pg = 8'h00;
          n.left = (q.len == 8'h00) ? 8'h01 : q.len;
          n.kind = K_AW;
          n.fin = 1'b0;
        end
      end
      M_CHK:
      begin
        if (!PIN_I.sda)
        begin
          n.res = RES_SDA_LOW;
          n.st = M_IDLE;
        end
        else if (!PIN_I.scl)
        begin
          n.res = RES_SCL_LOW;
          n.st = M_IDLE;
        end
        else
        begin
          n.res = RES_OK;
          n.st = M_STA;
        end
      end
      M_STA:
      begin
        if (bdone)
        begin
          // after a repeated start the read address follows
          n.sh = ihm_abyte(q.slv, q.kind == K_AR);
          n.bitn = 4'h0;
          n.st = M_TXB;
        end
      end
      M_TXB:
      begin
        if (bdone && (q.bitn != 4'h8))
        begin
          n.sh = {q.sh[6:0], 1'b0};
          n.bitn = q.bitn + 4'h1;
        end
        else if (bdone)
        begin
          n.bitn = 4'h0;
          if (nack & ~q.ign)
          begin
            n.fin = 1'b1;
            n.st = M_STO;
            if ((q.kind == K_AW) || (q.kind == K_AR))
              n.res = RES_ADDR_NACK;
            else
              n.res = RES_DATA_NACK;
          end
          else
          begin
            unique case (q.kind)
              K_AW:
              begin
                n.kind = K_SUB;
                n.sh = q.off;
              end
              K_SUB:
              begin
                if (q.rd)
                begin
                  n.kind = K_AR;
                  n.st = M_STA;
                end
                else
                begin
                  n.kind = K_DAT;
                  n.sh = q.mem[q.idx];
                end
              end
              K_AR:
                n.st = M_RXB;
              K_DAT:
              begin
                n.idx = q.idx + IW'(1);
                n.off = q.off + 8'h01;
                n.pg = q.pg + 8'h01;
                n.left = q.left - 8'h01;
                n.sh = q.mem[q.idx + IW'(1)];
                if (q.left == 8'h01)
                begin
                  n.fin = 1'b1;
                  n.st = M_STO;
                end
                else if (q.pgen && ((q.pg + 8'h01) == q.page))
                  n.st = M_STO;
              end
            endcase
          end
        end
      end
      M_RXB:
      begin
        if (bdone && (q.bitn != 4'h8))
        begin
          n.sh = {q.sh[6:0], brx};
          n.bitn = q.bitn + 4'h1;
        end
        else if (bdone)
        begin
          n.bitn = 4'h0;
          n.rxd = q.sh;
          n.fin = 1'b1;
          if (!brx)
            n.res = RES_RDACK_BAD;
          n.st = M_STO;
        end
      end
      M_STO:
      begin
        if (bdone && q.fin)
          n.st = M_IDLE;
        else if (bdone)
        begin
          // the eeprom would not answer its address before this ends
          n.tus = q.prog;
          n.pre = US_CYC - 7'h01;
          n.st = M_PROG;
        end
      end
      M_PROG:
      begin
        if (q.pre != 7'h00)
          n.pre = q.pre - 7'h01;
        else if (q.tus == 16'h0000)
        begin
          n.pg = 8'h00;
          n.kind = K_AW;
          n.st = M_STA;
        end
        else
        begin
          n.pre = US_CYC - 7'h01;
          n.tus = q.tus - 16'h0001;
        end
      end
      default:
        n.st = M_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      q <= '{st: M_IDLE, kind: K_AW, res: RES_OK, sclh: SCLH_RST, scll: SCLL_RST,
             page: PAGE_RST, freq: FREQ_RST, prog: PROG_RST, default: '0};
    else
      q <= n;
  end

  // bit engine shares the programmed counts
  ihm_bit u_bit (
    .clk    (REF_CLK),
    .arst_n (ARST_N),
    .hi_cnt (q.sclh),
    .lo_cnt (q.scll),
    .cmd    (bc),
    .rdy    (brdy),
    .done   (bdone),
    .rx     (brx),
    .pin_i  (PIN_I),
    .pin_o  (PIN_O)
  );

  assign AVS_RSP = '{waitrequest: req & ~q.ack, readdata: q.rdata};
endmodule

/* File: sim/ihm_slave.sv */
// behavioural two-wire slave: acks its address, keeps written bytes, returns one byte
// assumes scl and sda are resolved wires with pull-ups
`timescale 1ns/100ps
module ihm_slave #(
  parameter logic [6:0] ADDR = 7'h50,  // arbitrary test address
  parameter logic [7:0] RVAL = 8'h5A   // byte handed out on reads
)
(
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [2:0] mode,  // b0 programming, b1 refuse data, b2 spoil the nack
  output logic            sda_oe
);
  logic [7:0] b;       // shift register
  logic [7:0] got[$];  // every byte seen since cleared
  event       go;
  initial sda_oe = 1'b0;
  // a start restarts the session; nonblocking trigger avoids a race with the restart
  always @(negedge sda)
    if (scl === 1'b1)
    begin
      disable sess;
      sda_oe = 1'b0;
      ->> go;
    end
  // a stop ends it
  always @(posedge sda)
    if (scl === 1'b1)
      disable sess;
  task automatic rx8();
    repeat (8)
    begin
      @(posedge scl);
      b = {b[6:0], sda};
    end
    got.push_back(b);
  endtask
  task automatic ack(input logic a);
    @(negedge scl);
    sda_oe = a;
    @(negedge scl);
    sda_oe = 1'b0;
  endtask
  always @(go)
  begin : sess
    rx8();
    if (b[7:1] != ADDR || mode[0])
      disable sess;
    ack(1'b1);
    if (b[0])
    begin
      for (int i = 7; i >= 0; i--)
      begin
        sda_oe = !RVAL[i];
        @(negedge scl);
      end
      sda_oe = mode[2];  // pulls the master's nack slot only when told to
      @(negedge scl);
      sda_oe = 1'b0;
    end
    else
      forever
      begin
        rx8();
        ack(!mode[1]);
      end
  end
endmodule

/* File: sim/ihm_top_bench.sv */
// self-checking bench for the two-wire host master
// assumes the behavioural slave and the bound checker
`timescale 1ns/100ps
module ihm_top_bench;
  import ihm_pkg::*;
  logic         clk = 1'b0;
  logic         arst_n = 1'b0;
  ihm_avs_req_t req = '0;
  ihm_avs_rsp_t rsp;
  ihm_pin_out_t po;
  logic         s_oe;
  logic [1:0]   stuck = 2'b00;  // b1 holds scl low, b0 holds sda low
  logic [2:0]   mode = 3'h0;
  logic [31:0]  q;
  logic [31:0]  t;
  logic [7:0]   off;
  logic [7:0]   d[4];
  logic [5:0]   ra[6] = '{REG_SCLH, REG_SCLL, REG_PAGE, REG_FREQ, REG_PROG, 6'h30};
  logic [31:0]  rv[6] = '{32'h14, 32'h14, 32'h08, 32'hC8, 32'h1388, 32'h0};
  int           f;
  int           seed = 32'hbcb1;
  int           num_errors = 0;
  int           compares = 0;
  int           cyc = 0;
  wire          scl_w = !(po.scl_oe || stuck[1]);  // pull-up unless someone pulls
  wire          sda_w = !(po.sda_oe || s_oe || stuck[0]);
  always #5 clk = !clk;
  ihm_top uut (.REF_CLK(clk), .ARST_N(arst_n), .AVS_REQ(req), .AVS_RSP(rsp),
    .PIN_I({scl_w, sda_w}), .PIN_O(po));
  ihm_slave sl (.scl(scl_w), .sda(sda_w), .mode(mode), .sda_oe(s_oe));
  task automatic finish_test();
    if (num_errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one avalon access, called just after a rising edge; held until waitrequest is
  // sampled low at a rising edge, then released with one idle edge before the next
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] wd);
    int n = 0;
    req <= '{read: !w, write: w, address: a, writedata: wd};
    do @(posedge clk); while (rsp.waitrequest !== 1'b0 && ++n < 50);
    if (n >= 50)
      num_errors++;
    q = rsp.readdata;
    req <= '0;
    @(posedge clk);
  endtask
  // start a transfer, poll busy with a bound, check the result unless exp is negative
  task automatic run(input logic [31:0] ctl, input int exp);
    int n = 0;
    sl.got.delete();
    bus(1, REG_CTRL, ctl);
    do bus(0, REG_STAT, 0); while (q[STAT_BUSY] !== 1'b0 && ++n < 6000);
    if (n >= 6000)
      num_errors++;
    if (exp >= 0)
      chk(q[STAT_RES+:3], exp);
  endtask
  // nearest count sum split into high and low halves
  function automatic logic [15:0] split(input int fk);
    int s = (8000 + fk / 2) / fk;
    return {8'(s / 2), 8'(s - s / 2)};
  endfunction
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      num_errors++;
      finish_test();
    end
  end
  initial
  begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    foreach (ra[i])
    begin
      bus(0, ra[i], 0);
      chk(q, rv[i]);
    end
    repeat (3)
    begin
      f = 40 + ($random(seed) & 511);
      bus(1, REG_FREQ, f);
      bus(0, REG_SCLH, 0);
      t = q;
      bus(0, REG_SCLL, 0);
      chk({t[15:0], q[7:0]}, split(f));
    end
    bus(1, REG_SCLH, 1);
    bus(1, REG_SCLL, 3);
    bus(0, REG_SCLH, 0);
    chk(q, 3);
    off = $random(seed);
    bus(1, REG_SLV, 32'hA1);
    bus(1, REG_OFF, off);
    bus(1, REG_LEN, 4);
    bus(1, REG_PROG, 2);
    foreach (d[i])
    begin
      d[i] = $random(seed);
      bus(1, REG_WDAT, d[i]);
    end
    run(1, RES_OK);
    chk({8'(sl.got.size()), sl.got[0], sl.got[1], sl.got[5]},
        {8'h6, 8'hA0, off, d[3]});
    // a write moves the offset register on with the data, so set it again
    bus(1, REG_OFF, off);
    run(3, RES_OK);
    chk({8'(sl.got.size()), sl.got[0], sl.got[1], sl.got[2]},
        {8'h3, 8'hA0, off, 8'hA1});
    bus(0, REG_RDAT, 0);
    chk(q, 32'h5A);
    bus(1, REG_PAGE, 2);
    bus(1, REG_OFF, off);
    run(9, RES_OK);
    chk({8'(sl.got.size()), sl.got[4], sl.got[5], sl.got[7]},
        {8'h8, 8'hA0, off + 8'h2, d[3]});
    mode <= 3'h1;
    run(1, RES_ADDR_NACK);
    chk(sl.got.size(), 1);
    mode <= 3'h2;
    run(1, RES_DATA_NACK);
    chk(sl.got.size(), 2);
    run(5, RES_OK);
    chk(sl.got.size(), 6);
    mode <= 3'h4;
    run(3, RES_RDACK_BAD);
    mode <= 3'h0;
    stuck <= 2'b01;
    run(1, RES_SDA_LOW);
    stuck <= 2'b10;
    run(1, RES_SCL_LOW);
    chk(sl.got.size(), 0);
    finish_test();
  end
endmodule

/* File: sim/ihm_top_props.sv */
// checker for the two-wire host master ports
// assumes it is bound onto ihm_top with the pins resolved outside
`timescale 1ns/100ps
module ihm_top_props
(
  input wire logic                  REF_CLK,
  input wire logic                  ARST_N,
  input wire ihm_pkg::ihm_avs_req_t AVS_REQ,
  input wire ihm_pkg::ihm_avs_rsp_t AVS_RSP,
  input wire ihm_pkg::ihm_pin_in_t  PIN_I,
  input wire ihm_pkg::ihm_pin_out_t PIN_O
);
  import ihm_pkg::*;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  // sda moves while scl is let go: only a start or a stop may do that
  sequence s_start;
    $rose(PIN_O.sda_oe) && !PIN_O.scl_oe;
  endsequence
  sequence s_stop;
    $fell(PIN_O.sda_oe) && !PIN_O.scl_oe;
  endsequence
  AST_OPEN_DRAIN: assert property (!PIN_O.scl_o && !PIN_O.sda_o)
    else $error("pin driven high");
  AST_START_HOLD: assert property (s_start |=> !PIN_O.scl_oe [*3])
    else $error("scl pulled right after start");
  AST_STOP_SETUP: assert property (s_stop |-> $past(PIN_O.scl_oe, 3) == 1'b0)
    else $error("stop without scl high first");
  AST_SDA_STEADY: assert property ($fell(PIN_O.scl_oe) |=> $stable(PIN_O.sda_oe) [*4])
    else $error("sda moved after scl release");
  AST_LOW_MIN: assert property ($rose(PIN_O.scl_oe) |=> PIN_O.scl_oe [*8])
    else $error("scl low time too short");
  AST_HIGH_MIN: assert property ($fell(PIN_O.scl_oe) |=> !PIN_O.scl_oe [*8])
    else $error("scl high time too short");
  AST_STUCK: assert property ((!PIN_I.scl && !PIN_O.scl_oe) |-> !$rose(PIN_O.sda_oe))
    else $error("start with scl held low");
  AST_WAIT_ONE: assert property ($rose(AVS_REQ.read || AVS_REQ.write) |->
    AVS_RSP.waitrequest ##1 !AVS_RSP.waitrequest)
    else $error("access not answered after one cycle");
  AST_UPPER_ZERO: assert property ((AVS_REQ.read && !AVS_RSP.waitrequest) |->
    AVS_RSP.readdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
endmodule
bind ihm_top ihm_top_props chk (.REF_CLK(REF_CLK), .ARST_N(ARST_N), .AVS_REQ(AVS_REQ),
  .AVS_RSP(AVS_RSP), .PIN_I(PIN_I), .PIN_O(PIN_O));
